// ### hdl/lcsr_pkg.sv
/*
 * constants, field layout and state carrier for the link configuration and
 * status register bank (offsets 0x04 to 0x13 of the deserializer).
 * assumes a front end (control channel or serial management bus) that turns
 * each transaction into one byte-wide read or write strobe on the bank port.
 */
// Notes on behaviour
// - lock flag in 0x04 bit 7 is read-only and mirrors the lock pin level.
// - output enable bit loads from the enable pin level at power-up.
// - pattern test runs only while pattern check enable is set; resets to zero.
// - sleep bit power-up value comes from control direction and mode select pins.
// - two-bit base interface type picks base protocol; 00 after reset selects I2C.
// - reverse send and forward receive enables, both one after reset.
// - addressing method zero makes remote I2C master send register address.
// - equalizer gain four bits; 0100 when strap high, 1001 when low.
// - highpass cutoff two bits, reset 01; boost stays on while disable field zero.
// - error auto-clear bit clears error counters and error output; off after reset.
// - interrupt is forwarded across the link unless forward disable bit set.
// - read-only bit in 0x06 shows current interrupt output pin level.
// - each general-purpose pin driven from its drive bit; both reset to one.
// - read-only level bit per general-purpose pin returns its sampled input.
// - top bit of 0x06 at zero staggers output switching; zero by default.
// - sync glitch filters active unless disable bit in 0x08 set; reset zero.
// - eight-bit writable decoding error threshold at 0x0C, resets to zero.
// - read-only eight-bit decoding error count at 0x0D, zero after reset.
// - read-only eight-bit pattern error count at 0x0E, zero after reset.
// - master clock source zero derives audio master clock from pixel clock.
// - seven-bit audio master clock divider; zero turns the clock off.
// - mode select pin picks control-link mode while control direction pin high.

package lcsr_pkg;

    // ****************************************
    // register offsets
    // ****************************************
    localparam logic [7:0] LCSR_OFS_LINK_CONTROL   = 8'h04;
    localparam logic [7:0] LCSR_OFS_EQUALIZER      = 8'h05;
    localparam logic [7:0] LCSR_OFS_PIN_INTERRUPT  = 8'h06;
    localparam logic [7:0] LCSR_OFS_RESERVED_A     = 8'h07;
    localparam logic [7:0] LCSR_OFS_SYNC_FILTER    = 8'h08;
    localparam logic [7:0] LCSR_OFS_RESERVED_B     = 8'h09;
    localparam logic [7:0] LCSR_OFS_RESERVED_C     = 8'h0a;
    localparam logic [7:0] LCSR_OFS_RESERVED_D     = 8'h0b;
    localparam logic [7:0] LCSR_OFS_ERR_THRESHOLD  = 8'h0c;
    localparam logic [7:0] LCSR_OFS_DECODE_ERRORS  = 8'h0d;
    localparam logic [7:0] LCSR_OFS_PATTERN_ERRORS = 8'h0e;
    localparam logic [7:0] LCSR_OFS_MASTER_CLOCK   = 8'h12;
    localparam logic [7:0] LCSR_OFS_RESERVED_E     = 8'h13;

    // ****************************************
    // field positions
    // ****************************************
    // link_control
    localparam int LCSR_LC_LOCK     = 7;
    localparam int LCSR_LC_OUT_EN   = 6;
    localparam int LCSR_LC_PATTERN  = 5;
    localparam int LCSR_LC_SLEEP    = 4;
    localparam int LCSR_LC_ITYPE_HI = 3;
    localparam int LCSR_LC_ITYPE_LO = 2;
    localparam int LCSR_LC_REV_EN   = 1;
    localparam int LCSR_LC_FWD_EN   = 0;
    // equalizer_config
    localparam int LCSR_EQ_METHOD   = 7;
    localparam int LCSR_EQ_HPF_HI   = 6;
    localparam int LCSR_EQ_HPF_LO   = 5;
    localparam int LCSR_EQ_BOOST    = 4;
    localparam int LCSR_EQ_GAIN_HI  = 3;
    localparam int LCSR_EQ_GAIN_LO  = 0;
    // pin_interrupt_control
    localparam int LCSR_PI_NO_STAG  = 7;
    localparam int LCSR_PI_AUTOCLR  = 6;
    localparam int LCSR_PI_INT_DIS  = 5;
    localparam int LCSR_PI_INT_LVL  = 4;
    localparam int LCSR_PI_GP1_DRV  = 3;
    localparam int LCSR_PI_GP1_LVL  = 2;
    localparam int LCSR_PI_GP0_DRV  = 1;
    localparam int LCSR_PI_GP0_LVL  = 0;
    // sync_filter_control
    localparam int LCSR_SF_VS_DIS   = 1;
    localparam int LCSR_SF_HS_DIS   = 0;
    // master_clock_control
    localparam int LCSR_MC_SRC      = 7;

    // writable bits of the mixed registers; read-only bits are masked off, except the pin 0 level bit of 0x06
    localparam logic [7:0] LCSR_WMASK_LINK_CONTROL  = 8'h7f;
    localparam logic [7:0] LCSR_WMASK_PIN_INTERRUPT = 8'heb;

    // ****************************************
    // values after reset
    // ****************************************
    localparam logic [7:0] LCSR_RST_LINK_CONTROL  = 8'h03;
    localparam logic [7:0] LCSR_RST_EQUALIZER     = 8'h20;
    localparam logic [7:0] LCSR_RST_PIN_INTERRUPT = 8'h0a;
    localparam logic [7:0] LCSR_RST_RESERVED_A    = 8'h54;
    localparam logic [7:0] LCSR_RST_SYNC_FILTER   = 8'h30;
    localparam logic [7:0] LCSR_RST_RESERVED_B    = 8'hc8;
    localparam logic [7:0] LCSR_RST_RESERVED_C    = 8'h12;
    localparam logic [7:0] LCSR_RST_RESERVED_D    = 8'h20;
    localparam logic [7:0] LCSR_RST_THRESHOLD     = 8'h00;
    localparam logic [7:0] LCSR_RST_COUNT         = 8'h00;
    localparam logic [7:0] LCSR_RST_MASTER_CLOCK  = 8'h00;
    localparam logic [7:0] LCSR_RST_RESERVED_E    = 8'h10;
    localparam logic [3:0] LCSR_GAIN_STRAP_HIGH   = 4'h4;
    localparam logic [3:0] LCSR_GAIN_STRAP_LOW    = 4'h9;
    localparam logic [7:0] LCSR_COUNT_MAX         = 8'hff;
    localparam logic [7:0] LCSR_READ_UNMAPPED     = 8'h00;

    // ****************************************
    // state carriers
    // ****************************************
    typedef struct packed {
        logic [7:0] link_control;
        logic [7:0] equalizer_config;
        logic [7:0] pin_interrupt_control;
        logic [7:0] reserved_a;
        logic [7:0] sync_filter_control;
        logic [7:0] reserved_b;
        logic [7:0] reserved_c;
        logic [7:0] reserved_d;
        logic [7:0] error_threshold;
        logic [7:0] master_clock_control;
        logic [7:0] reserved_e;
        logic [7:0] rdata;
        logic       straps_pending;
        logic       lock_prev;
        logic       pattern_prev;
        logic       error_out;
        logic       ctl_mode_valid;
        logic       ctl_mode;
    } lcsr_state_s;

    typedef struct packed {
        logic [7:0] count;
    } lcsr_count_state_s;

endpackage : lcsr_pkg

// ### hdl/lcsr_err_counter.sv
/*
 * saturating eight-bit error counter with a clear input.
 * assumes error events are single-cycle pulses synchronous to clk.
 */
`timescale 1ns/1ns

module lcsr_err_counter
    import lcsr_pkg::*;
(
    input  wire logic       clk,    // core clock
    input  wire logic       reset,  // asynchronous, active high
    input  wire logic       event_p, // one error seen this cycle
    input  wire logic       clear,  // restart the count
    output logic      [7:0] count   // current count
);

    lcsr_count_state_s state_ff;
    lcsr_count_state_s nxt_state;

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        nxt_state = state_ff;
        if (clear) begin
            // an error in the clearing cycle is kept, not lost
            nxt_state.count = event_p ? 8'h01 : LCSR_RST_COUNT;
        end else if (event_p && state_ff.count != LCSR_COUNT_MAX) begin
            nxt_state.count = state_ff.count + 8'h01;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_ff <= '{count: LCSR_RST_COUNT};
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign count = state_ff.count;

endmodule : lcsr_err_counter

// ### hdl/lcsr_regs.sv
/*
 * link configuration and status register bank, offsets 0x04 to 0x13.
 * holds control bits for lock reporting, output enable, sleep, pattern test,
 * control channel directions, equalizer, interrupt and general-purpose pins,
 * sync filters, error counting and the audio master clock.
 * assumes the control channel / serial bus front end presents one byte access
 * per strobe, and that all pins arrive synchronous to clk.
 */
`timescale 1ns/1ns

module lcsr_regs
    import lcsr_pkg::*;
(
    input  wire logic       clk,                  // core clock, 100 MHz
    input  wire logic       reset,                // asynchronous, active high
    // register access from the control front end
    input  wire logic [7:0] reg_addr,             // byte offset
    input  wire logic       reg_wr,               // write strobe
    input  wire logic       reg_rd,               // read strobe
    input  wire logic [7:0] reg_wdata,            // write data
    output logic      [7:0] reg_rdata,            // read data, valid after reg_rd
    // pin levels
    input  wire logic       lock_pin,             // link lock output level
    input  wire logic       enable_pin,           // output enable strap
    input  wire logic       control_direction_select, // control direction strap
    input  wire logic       mode_select_pin,      // mode select strap
    input  wire logic       equalizer_strap_pin,  // equalizer strap
    input  wire logic       int_pin,              // interrupt output level
    input  wire logic       gp_pin1_in,           // general-purpose pin 1 input
    input  wire logic       gp_pin0_in,           // general-purpose pin 0 input
    // error events
    input  wire logic       decode_error,         // one line decoding error
    input  wire logic       pattern_error,        // one pattern test error
    // control outputs
    output logic            output_enable_bit,    // output drivers enabled
    output logic            pattern_check_enable, // pattern test running
    output logic            sleep,                // sleep mode request
    output logic      [1:0] base_interface_type,  // base-mode protocol
    output logic            reverse_channel_enable, // send on reverse channel
    output logic            forward_channel_enable, // receive on forward channel
    output logic            master_addressing_method, // 0: send register address
    output logic      [1:0] highpass_cutoff_select, // equalizer highpass tune
    output logic            boost_disable,        // high-frequency boost field
    output logic      [3:0] equalizer_gain_select, // equalizer gain
    output logic            error_auto_clear,     // automatic error clearing
    output logic            interrupt_forward_en, // interrupt carried over link
    output logic            gp_pin1_drive_value,  // drive for pin 1
    output logic            gp_pin0_drive_value,  // drive for pin 0
    output logic            stagger_enable,       // stagger output switching
    output logic            vsync_filter_en,      // vertical sync glitch filter
    output logic            hsync_filter_en,      // horizontal sync glitch filter
    output logic            error_out,            // decode errors above threshold
    output logic            audio_master_clock_source, // 0: from pixel clock
    output logic      [6:0] audio_master_clock_divider, // 0: clock off
    output logic            audio_master_clock_en, // master clock running
    output logic            ctl_mode_valid,       // control mode valid while direction pin high
    output logic            ctl_mode              // control-link mode from pin
);

    lcsr_state_s state_ff;
    lcsr_state_s nxt_state;
    logic  [7:0] decode_error_count;
    logic  [7:0] pattern_error_count;
    logic        decode_clear;
    logic        pattern_clear;
    logic        lock_rise;
    logic        pattern_rise;
    logic        pattern_event;
    logic  [7:0] read_value;

    // ****************************************
    // error counters
    // ****************************************
    assign lock_rise     = lock_pin && !state_ff.lock_prev;
    assign pattern_rise  = state_ff.link_control[LCSR_LC_PATTERN] && !state_ff.pattern_prev;
    // errors outside a running test are not counted
    assign pattern_event = pattern_error && state_ff.link_control[LCSR_LC_PATTERN];

    // auto-clear restarts the counters each time the link comes back into lock
    assign decode_clear  = state_ff.pin_interrupt_control[LCSR_PI_AUTOCLR] && lock_rise;
    assign pattern_clear = (state_ff.pin_interrupt_control[LCSR_PI_AUTOCLR] && lock_rise)
                         || pattern_rise;

    lcsr_err_counter u_decode_count (
        .clk     (clk),
        .reset   (reset),
        .event_p (decode_error),
        .clear   (decode_clear),
        .count   (decode_error_count)
    );

    lcsr_err_counter u_pattern_count (
        .clk     (clk),
        .reset   (reset),
        .event_p (pattern_event),
        .clear   (pattern_clear),
        .count   (pattern_error_count)
    );

    // ****************************************
    // read multiplexer
    // ****************************************
    always_comb begin
        read_value = LCSR_READ_UNMAPPED;
        unique case (reg_addr)
            LCSR_OFS_LINK_CONTROL: begin
                read_value                = state_ff.link_control;
                read_value[LCSR_LC_LOCK]  = lock_pin;
            end
            LCSR_OFS_EQUALIZER:      read_value = state_ff.equalizer_config;
            LCSR_OFS_PIN_INTERRUPT: begin
                read_value                   = state_ff.pin_interrupt_control;
                read_value[LCSR_PI_INT_LVL]  = int_pin;
                read_value[LCSR_PI_GP1_LVL]  = gp_pin1_in;
                read_value[LCSR_PI_GP0_LVL]  = gp_pin0_in;
            end
            LCSR_OFS_RESERVED_A:     read_value = state_ff.reserved_a;
            LCSR_OFS_SYNC_FILTER:    read_value = state_ff.sync_filter_control;
            LCSR_OFS_RESERVED_B:     read_value = state_ff.reserved_b;
            LCSR_OFS_RESERVED_C:     read_value = state_ff.reserved_c;
            LCSR_OFS_RESERVED_D:     read_value = state_ff.reserved_d;
            LCSR_OFS_ERR_THRESHOLD:  read_value = state_ff.error_threshold;
            LCSR_OFS_DECODE_ERRORS:  read_value = decode_error_count;
            LCSR_OFS_PATTERN_ERRORS: read_value = pattern_error_count;
            LCSR_OFS_MASTER_CLOCK:   read_value = state_ff.master_clock_control;
            LCSR_OFS_RESERVED_E:     read_value = state_ff.reserved_e;
            default:                 read_value = LCSR_READ_UNMAPPED;
        endcase
    end

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        nxt_state              = state_ff;
        nxt_state.lock_prev    = lock_pin;
        nxt_state.pattern_prev = state_ff.link_control[LCSR_LC_PATTERN];

        if (reg_rd) begin
            nxt_state.rdata = read_value;
        end

        if (reg_wr) begin
            unique case (reg_addr)
                LCSR_OFS_LINK_CONTROL: begin
                    // lock flag is status only
                    nxt_state.link_control = reg_wdata & LCSR_WMASK_LINK_CONTROL;
                end
                LCSR_OFS_EQUALIZER:     nxt_state.equalizer_config = reg_wdata;
                LCSR_OFS_PIN_INTERRUPT: begin
                    nxt_state.pin_interrupt_control = reg_wdata & LCSR_WMASK_PIN_INTERRUPT;
                end
                // reserved bytes hold whatever is written back; only defaults are meaningful
                LCSR_OFS_RESERVED_A:    nxt_state.reserved_a = reg_wdata;
                LCSR_OFS_SYNC_FILTER:   nxt_state.sync_filter_control = reg_wdata;
                LCSR_OFS_RESERVED_B:    nxt_state.reserved_b = reg_wdata;
                LCSR_OFS_RESERVED_C:    nxt_state.reserved_c = reg_wdata;
                LCSR_OFS_RESERVED_D:    nxt_state.reserved_d = reg_wdata;
                LCSR_OFS_ERR_THRESHOLD: nxt_state.error_threshold = reg_wdata;
                LCSR_OFS_MASTER_CLOCK:  nxt_state.master_clock_control = reg_wdata;
                LCSR_OFS_RESERVED_E:    nxt_state.reserved_e = reg_wdata;
                // counters and unmapped offsets ignore writes
                default: begin
                    nxt_state.rdata = nxt_state.rdata;
                end
            endcase
        end

        // straps are caught on the first edge after reset release, and win over
        // a write that lands in that same cycle
        if (state_ff.straps_pending) begin
            nxt_state.straps_pending                   = 1'b0;
            nxt_state.link_control[LCSR_LC_OUT_EN]     = enable_pin;
            nxt_state.link_control[LCSR_LC_SLEEP]      =
                control_direction_select && mode_select_pin;
            nxt_state.equalizer_config[LCSR_EQ_GAIN_HI:LCSR_EQ_GAIN_LO] =
                equalizer_strap_pin ? LCSR_GAIN_STRAP_HIGH : LCSR_GAIN_STRAP_LOW;
        end

        // error output: decode errors above threshold, dropped with the count
        if (decode_clear) begin
            nxt_state.error_out = decode_error;
        end else begin
            nxt_state.error_out = (decode_error_count > state_ff.error_threshold);
        end

        // mode pin names the control-link mode only with direction pin high
        nxt_state.ctl_mode_valid = control_direction_select;
        nxt_state.ctl_mode       = control_direction_select && mode_select_pin;
    end

    // ****************************************
    // state register
    // ****************************************
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_ff <= '{
                link_control:          LCSR_RST_LINK_CONTROL,
                equalizer_config:      LCSR_RST_EQUALIZER,
                pin_interrupt_control: LCSR_RST_PIN_INTERRUPT,
                reserved_a:            LCSR_RST_RESERVED_A,
                sync_filter_control:   LCSR_RST_SYNC_FILTER,
                reserved_b:            LCSR_RST_RESERVED_B,
                reserved_c:            LCSR_RST_RESERVED_C,
                reserved_d:            LCSR_RST_RESERVED_D,
                error_threshold:       LCSR_RST_THRESHOLD,
                master_clock_control:  LCSR_RST_MASTER_CLOCK,
                reserved_e:            LCSR_RST_RESERVED_E,
                rdata:                 LCSR_READ_UNMAPPED,
                straps_pending:        1'b1,
                lock_prev:             1'b0,
                pattern_prev:          1'b0,
                error_out:             1'b0,
                ctl_mode_valid:        1'b0,
                ctl_mode:              1'b0
            };
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign reg_rdata                 = state_ff.rdata;

    assign output_enable_bit         = state_ff.link_control[LCSR_LC_OUT_EN];
    assign pattern_check_enable      = state_ff.link_control[LCSR_LC_PATTERN];
    assign sleep                     = state_ff.link_control[LCSR_LC_SLEEP];
    assign base_interface_type       =
        state_ff.link_control[LCSR_LC_ITYPE_HI:LCSR_LC_ITYPE_LO];
    assign reverse_channel_enable    = state_ff.link_control[LCSR_LC_REV_EN];
    assign forward_channel_enable    = state_ff.link_control[LCSR_LC_FWD_EN];

    assign master_addressing_method  = state_ff.equalizer_config[LCSR_EQ_METHOD];
    assign highpass_cutoff_select    =
        state_ff.equalizer_config[LCSR_EQ_HPF_HI:LCSR_EQ_HPF_LO];
    // boost is only off when this field is written to one
    assign boost_disable             = state_ff.equalizer_config[LCSR_EQ_BOOST];
    assign equalizer_gain_select     =
        state_ff.equalizer_config[LCSR_EQ_GAIN_HI:LCSR_EQ_GAIN_LO];

    assign error_auto_clear          = state_ff.pin_interrupt_control[LCSR_PI_AUTOCLR];
    assign interrupt_forward_en      = !state_ff.pin_interrupt_control[LCSR_PI_INT_DIS];
    assign gp_pin1_drive_value       = state_ff.pin_interrupt_control[LCSR_PI_GP1_DRV];
    assign gp_pin0_drive_value       = state_ff.pin_interrupt_control[LCSR_PI_GP0_DRV];
    assign stagger_enable            = !state_ff.pin_interrupt_control[LCSR_PI_NO_STAG];

    assign vsync_filter_en           = !state_ff.sync_filter_control[LCSR_SF_VS_DIS];
    assign hsync_filter_en           = !state_ff.sync_filter_control[LCSR_SF_HS_DIS];

    assign error_out                 = state_ff.error_out;

    assign audio_master_clock_source = state_ff.master_clock_control[LCSR_MC_SRC];
    assign audio_master_clock_divider = state_ff.master_clock_control[6:0];
    // a zero divider stops the master clock rather than dividing by zero
    assign audio_master_clock_en     = (state_ff.master_clock_control[6:0] != 7'h00);

    assign ctl_mode_valid            = state_ff.ctl_mode_valid;
    assign ctl_mode                  = state_ff.ctl_mode;

endmodule : lcsr_regs

// ### verif/lcsr_checker.sv
/* port assertions for the register bank.
   assumes the bench never writes in the first edge after reset release. */
`timescale 1ns/1ns
module lcsr_checker (
    input wire logic       clk, reset, reg_wr, reg_rd, lock_pin, int_pin, gp_pin1_in, gp_pin0_in, // bus, pins
    input wire logic [7:0] reg_addr, reg_wdata, reg_rdata, // register port
    input wire logic       output_enable_bit, pattern_check_enable, sleep, reverse_channel_enable, // link
    input wire logic       forward_channel_enable, master_addressing_method, boost_disable, stagger_enable, // cfg
    input wire logic       interrupt_forward_en, gp_pin1_drive_value, vsync_filter_en, hsync_filter_en, // pins
    input wire logic       audio_master_clock_source, audio_master_clock_en, decode_error, // clock, events
    input wire logic [1:0] base_interface_type, highpass_cutoff_select, // fields
    input wire logic [3:0] equalizer_gain_select, // gain
    input wire logic [6:0] audio_master_clock_divider // divider
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    link_write_a: assert property (reg_wr && reg_addr == 8'h04 |=> {output_enable_bit, pattern_check_enable, sleep,
        base_interface_type, reverse_channel_enable, forward_channel_enable} == $past(reg_wdata[6:0]))
        else $error("link control write lost");
    eq_write_a: assert property (reg_wr && reg_addr == 8'h05 |=> {master_addressing_method, highpass_cutoff_select,
        boost_disable, equalizer_gain_select} == $past(reg_wdata)) else $error("equalizer write lost");
    pin_write_a: assert property (reg_wr && reg_addr == 8'h06 |=> stagger_enable == !$past(reg_wdata[7])
        && interrupt_forward_en == !$past(reg_wdata[5]) && gp_pin1_drive_value == $past(reg_wdata[3]))
        else $error("pin control write lost");
    sync_filter_a: assert property (reg_wr && reg_addr == 8'h08 |=>
        {vsync_filter_en, hsync_filter_en} == ~$past(reg_wdata[1:0])) else $error("filter enable wrong");
    mclk_write_a: assert property (reg_wr && reg_addr == 8'h12 |=>
        {audio_master_clock_source, audio_master_clock_divider} == $past(reg_wdata)) else $error("mclk write lost");
    mclk_off_a: assert property ((audio_master_clock_divider == 7'h00) == !audio_master_clock_en)
        else $error("mclk enable wrong");
    lock_read_a: assert property (reg_rd && reg_addr == 8'h04 |=> reg_rdata[7] == $past(lock_pin))
        else $error("lock flag wrong");
    level_read_a: assert property (reg_rd && reg_addr == 8'h06 |=> {reg_rdata[4], reg_rdata[2], reg_rdata[0]}
        == $past({int_pin, gp_pin1_in, gp_pin0_in})) else $error("pin levels wrong");
    cover property (reg_wr && reg_addr == 8'h04);
    cover property (reg_rd && reg_addr == 8'h06);
    cover property (decode_error ##1 decode_error);
endmodule : lcsr_checker
bind lcsr_regs lcsr_checker lcsr_checker_i (.*);

// ### verif/lcsr_mcu.sv
/* microcontroller model: one byte per strobe.
   assumes the bank takes a strobe at the edge after it is raised. */
`timescale 1ns/1ns
module lcsr_mcu (
    input  wire logic       clk,       // core clock
    output logic      [7:0] reg_addr,  // offset
    output logic            reg_wr,    // write strobe
    output logic            reg_rd,    // read strobe
    output logic      [7:0] reg_wdata, // write data
    input  wire logic [7:0] reg_rdata  // read data
);
    initial {reg_addr, reg_wr, reg_rd, reg_wdata} = '0;
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
        @(posedge clk);
        // stale data must not look valid once the strobe drops
        {reg_wdata, reg_wr} <= {~d, 1'b0};
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        {reg_addr, reg_rd} <= {a, 1'b1};
        @(posedge clk);
        reg_rd <= 1'b0;
        @(posedge clk);
        d = reg_rdata;
    endtask : rd
endmodule : lcsr_mcu

// ### verif/testbench.sv
/* self-checking bench for lcsr_regs; straps: enable high, mode low, eq low. */
`timescale 1ns/1ns
module testbench;
    logic clk = 0, reset = 1, lock_pin = 0, enable_pin = 1, control_direction_select = 1, mode_select_pin = 0;
    logic equalizer_strap_pin = 0, int_pin = 0, gp_pin1_in = 1, gp_pin0_in = 1, decode_error = 0, pattern_error = 0;
    logic output_enable_bit, pattern_check_enable, sleep, reverse_channel_enable, forward_channel_enable, reg_wr;
    logic master_addressing_method, boost_disable, error_auto_clear, interrupt_forward_en, gp_pin1_drive_value;
    logic gp_pin0_drive_value, stagger_enable, vsync_filter_en, hsync_filter_en, error_out, audio_master_clock_en;
    logic audio_master_clock_source, ctl_mode_valid, ctl_mode, reg_rd;
    logic [1:0] base_interface_type, highpass_cutoff_select;
    logic [3:0] equalizer_gain_select;
    logic [6:0] audio_master_clock_divider;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, got;
    logic [7:0] ra [14] = '{8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h12, 8'h13, 8'h10};
    logic [7:0] rv [14] = '{8'h43, 8'h29, 8'h0f, 8'h54, 8'h30, 8'hc8, 8'h12, 8'h20, 8'h00, 8'h00, 8'h00, 8'h00, 8'h10, 8'h00};
    int err_total = 0, check_count = 0;
    lcsr_regs lcsr_regs_i (.*);
    lcsr_mcu lcsr_mcu_i (.*);
    always #5 clk = ~clk;
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        check_count++;
        if (g !== e) begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
        lcsr_mcu_i.rd(a, got);
        chk(got, e);
    endtask : rdchk
    task automatic pulse(input int n);
        repeat (n) @(posedge clk) {decode_error, pattern_error} <= 2'b11;
        @(posedge clk) {decode_error, pattern_error} <= 2'b00;
    endtask : pulse
    task automatic results;
        $display("checks=%0d errors=%0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : results
    initial begin
        #200000 err_total++;
        results();
    end
    initial begin
        repeat (12) @(posedge clk);
        reset <= 0;
        repeat (2) @(posedge clk);
        for (int i = 0; i < 14; i++) rdchk(ra[i], rv[i]);
        chk({4'h0, gp_pin1_drive_value, gp_pin0_drive_value, ctl_mode_valid, ctl_mode}, 8'h0e);
        lcsr_mcu_i.wr(8'h0d, 8'hff);
        lcsr_mcu_i.wr(8'h0e, 8'hff);
        pulse(1);
        rdchk(8'h0e, 8'h00);
        lcsr_mcu_i.wr(8'h04, 8'hff);
        lcsr_mcu_i.wr(8'h0c, 8'h02);
        pulse(2);
        rdchk(8'h0d, 8'h03);
        rdchk(8'h0e, 8'h02);
        chk({7'h00, error_out}, 8'h01);
        rdchk(8'h04, 8'h7f);
        lock_pin <= 1;
        rdchk(8'h04, 8'hff);
        lcsr_mcu_i.wr(8'h06, 8'h40);
        lock_pin <= 0;
        repeat (3) @(posedge clk);
        chk({4'h0, error_auto_clear, interrupt_forward_en, gp_pin1_drive_value, gp_pin0_drive_value}, 8'h0c);
        lock_pin <= 1;
        repeat (4) @(posedge clk);
        rdchk(8'h0d, 8'h00);
        rdchk(8'h0e, 8'h00);
        chk({7'h00, error_out}, 8'h00);
        {int_pin, gp_pin0_in} <= 2'b10;
        rdchk(8'h06, 8'h54);
        lcsr_mcu_i.wr(8'h12, 8'h85);
        rdchk(8'h12, 8'h85);
        lcsr_mcu_i.wr(8'h05, 8'hb6);
        rdchk(8'h05, 8'hb6);
        lcsr_mcu_i.wr(8'h08, 8'h33);
        rdchk(8'h08, 8'h33);
        results();
    end
endmodule : testbench
